// file: inc/hbwd_pkg.sv
/*
 * Shared constants and types of the heartbeat watchdog: command codes,
 * timing figures, counter widths and the sequencer state encoding.
 * Assumes a single 200 MHz clock feeds every module that imports it.
 */
`default_nettype none

package hbwd_pkg;

    // ************************************************************
    // Clock and time base
    // ************************************************************

    // Clock rate in MHz; one clock period is 5 ns.
    localparam int unsigned CLK_MHZ        = 200;
    // The watchdog counts in 1 ms ticks to keep its counters narrow.
    localparam int unsigned TICK_PERIOD_US = 1000;
    localparam int unsigned TICK_CYCLES    = TICK_PERIOD_US * CLK_MHZ;
    localparam int unsigned TICK_W         = 18;

    // ************************************************************
    // Watchdog timing
    // ************************************************************

    // Longest allowed gap between two clears, in seconds.
    localparam int unsigned TIMEOUT_S      = 3;
    localparam int unsigned MS_PER_S       = 1000;
    localparam int unsigned MS_W           = 12;
    localparam logic [MS_W-1:0] TIMEOUT_MS = MS_W'(TIMEOUT_S * MS_PER_S);
    // Default mirror shutdown interval in ms, held until reset.
    localparam int unsigned SHUTDOWN_MS    = 2000;
    // Length of the system reset pulse, in clock cycles.
    localparam int unsigned RST_W          = 4;
    localparam logic [RST_W-1:0] RST_CYCLES = 4'h8;

    // ************************************************************
    // Command codes and states
    // ************************************************************

    localparam logic [1:0] CMD_DISABLE = 2'h0;
    localparam logic [1:0] CMD_ENABLE  = 2'h1;
    localparam logic [1:0] CMD_CLEAR   = 2'h2;

    typedef enum logic [1:0] {
        HBWD_DISABLED  = 2'b00,
        HBWD_ARMED     = 2'b01,
        HBWD_SHUTDOWN  = 2'b10,
        HBWD_RESETTING = 2'b11
    } hbwd_state_t;

endpackage : hbwd_pkg

`default_nettype wire

// file: inc/hbwd_tick_if.sv
/*
 * Carrier between the watchdog sequencer and its millisecond tick
 * generator. Assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none

interface hbwd_tick_if;
    logic restart;  // Realign the tick phase to now.
    logic tick;     // One-cycle pulse every millisecond.

    modport gen  (input restart, output tick);
    modport user (output restart, input tick);
endinterface : hbwd_tick_if

`default_nettype wire

// file: hdl/hbwd_tick_gen.sv
/*
 * Millisecond enable generator for the heartbeat watchdog.
 * Assumes restart comes from logic on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none

module hbwd_tick_gen
    import hbwd_pkg::*;
#(
    parameter int unsigned TICKS = TICK_CYCLES  // Clock cycles per tick.
) (
    input  wire logic   ref_clk,  // 200 MHz clock.
    input  wire logic   arst_n,   // Asynchronous reset, active low.
    hbwd_tick_if.gen    tk        // Restart in, tick out.
);

    typedef struct packed {
        logic [TICK_W-1:0] cnt;
    } hbwd_tick_regs_t;

    localparam logic [TICK_W-1:0] LAST = TICK_W'(TICKS - 1);

    hbwd_tick_regs_t r;
    hbwd_tick_regs_t next_r;

    // ************************************************************
    // Divider
    // ************************************************************

    // A restart zeroes the phase so a clear buys a full interval.
    always_comb begin
        next_r = r;
        if (tk.restart || r.cnt == LAST) begin
            next_r.cnt = '0;
        end else begin
            next_r.cnt = r.cnt + 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // The tick is a handshake-like enable, so it may be combinational.
    assign tk.tick = (r.cnt == LAST) && !tk.restart;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    tick_spacing_a: assert property (  // (R3)
        tk.tick |=> !tk.tick)
        else $error("Tick pulses ran back to back.");

endmodule : hbwd_tick_gen

`default_nettype wire

// file: hdl/hbwd_watchdog.sv
/*
 * Heartbeat watchdog top: takes enable, disable and clear commands,
 * times the clear interval, raises the backplane shutdown line on
 * expiry and then pulses the system reset.
 * Assumes the command strobe comes from logic on ref_clk.
 */
// Contract
// (R1) Parameter 0 disables, 1 enables, 2 clears the timeout interval.
// (R2) Master clears at least every 3 seconds while operation is normal.
// (R3) Missed clear starts mirror shutdown, then reset after shutdown time.
// (R4) Hardware logic raises backplane shutdown before the system reset.
// (R5) Backplane shutdown starts board safe shutdown ahead of reset.
// (R6) Master stops clearing when replies fail, forcing expiry.
// (R7) After watchdog reset completes, watchdog returns to disabled.
`timescale 1ns/100ps
`default_nettype none

module hbwd_watchdog
    import hbwd_pkg::*;
#(
    parameter int unsigned TICKS       = TICK_CYCLES,     // Cycles per ms.
    parameter logic [MS_W-1:0] SHUT_MS = MS_W'(SHUTDOWN_MS) // Shutdown, ms.
) (
    input  wire logic       ref_clk,            // 200 MHz clock.
    input  wire logic       arst_n,             // Async reset, active low.
    input  wire logic       cmd_valid,          // Command strobe.
    input  wire logic [1:0] cmd_param,          // Command parameter.
    output logic            cmd_ready,          // Command can be taken.
    output logic            wdg_enabled,        // Watchdog armed.
    output logic            backplane_shutdown, // Safe shutdown request.
    output logic            system_reset        // Whole-system reset.
);

    typedef struct packed {
        hbwd_state_t      state;
        logic [MS_W-1:0]  ms_count;
        logic [RST_W-1:0] rst_count;
        logic             shutdown;
        logic             sys_reset;
    } hbwd_regs_t;

    hbwd_regs_t  r;
    hbwd_regs_t  next_r;
    hbwd_tick_if tk ();
    logic        cmd_take;

    hbwd_tick_gen #(
        .TICKS (TICKS)
    ) u_tick (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .tk      (tk)
    );

    // ************************************************************
    // Command acceptance
    // ************************************************************

    // Once expiry has started the sequence always runs to the end, so
    // commands are refused; a late clear must not abort a shutdown
    // that the boards have already begun.
    assign cmd_ready = (r.state == HBWD_DISABLED)
                    || (r.state == HBWD_ARMED);
    assign cmd_take  = cmd_valid && cmd_ready;

    // (R1) Clear and enable realign the tick phase.
    assign tk.restart = cmd_take
        && ((cmd_param == CMD_CLEAR && r.state == HBWD_ARMED)
        || (cmd_param == CMD_ENABLE && r.state == HBWD_DISABLED));

    // ************************************************************
    // Sequencer
    // ************************************************************

    always_comb begin
        next_r = r;
        unique case (r.state)
            HBWD_DISABLED: begin
                // (R1) Enable command arms the timer.
                if (cmd_take && cmd_param == CMD_ENABLE) begin
                    next_r.state    = HBWD_ARMED;
                    next_r.ms_count = '0;
                end
            end
            HBWD_ARMED: begin
                // (R1) Disable and clear commands.
                if (cmd_take && cmd_param == CMD_DISABLE) begin
                    next_r.state    = HBWD_DISABLED;
                    next_r.ms_count = '0;
                end else if (cmd_take && cmd_param == CMD_CLEAR) begin
                    next_r.ms_count = '0;
                end else if (tk.tick) begin
                    // (R3) Missed clear starts shutdown.
                    if (r.ms_count == TIMEOUT_MS - 1'b1) begin
                        next_r.state    = HBWD_SHUTDOWN;
                        next_r.ms_count = '0;
                        next_r.shutdown = 1'b1;
                    end else begin
                        next_r.ms_count = r.ms_count + 1'b1;
                    end
                end
            end
            HBWD_SHUTDOWN: begin
                // (R4) Reset only after the shutdown interval.
                if (tk.tick) begin
                    if (r.ms_count == SHUT_MS - 1'b1) begin
                        next_r.state     = HBWD_RESETTING;
                        next_r.ms_count  = '0;
                        next_r.rst_count = '0;
                        next_r.sys_reset = 1'b1;
                    end else begin
                        next_r.ms_count = r.ms_count + 1'b1;
                    end
                end
            end
            HBWD_RESETTING: begin
                // (R7) Reset pulse ends in the disabled state.
                if (r.rst_count == RST_CYCLES - 1'b1) begin
                    next_r.state     = HBWD_DISABLED;
                    next_r.rst_count = '0;
                    next_r.sys_reset = 1'b0;
                    next_r.shutdown  = 1'b0;
                end else begin
                    next_r.rst_count = r.rst_count + 1'b1;
                end
            end
        endcase
    end

    // The whole state is one register; reset leaves it disabled.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            r <= '{state: HBWD_DISABLED, default: '0};
        end else begin
            r <= next_r;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************

    // (R5) Shutdown line held through the reset pulse.
    assign backplane_shutdown = r.shutdown;
    assign system_reset       = r.sys_reset;
    assign wdg_enabled        = (r.state == HBWD_ARMED);

    // ************************************************************
    // Checks
    // ************************************************************

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    sequence s_expire;
        r.state == HBWD_ARMED && !cmd_valid && tk.tick
            && r.ms_count == TIMEOUT_MS - 1'b1;
    endsequence

    sequence s_shut_end;
        r.state == HBWD_SHUTDOWN && tk.tick && r.ms_count == SHUT_MS - 1'b1;
    endsequence

    enable_arms_a: assert property (  // (R1)
        r.state == HBWD_DISABLED && cmd_valid && cmd_param == CMD_ENABLE
        |=> wdg_enabled && r.ms_count == '0)
        else $error("Enable did not arm the watchdog.");

    disable_stops_a: assert property (  // (R1)
        r.state == HBWD_ARMED && cmd_valid && cmd_param == CMD_DISABLE
        |=> r.state == HBWD_DISABLED && !backplane_shutdown)
        else $error("Disable did not stop the watchdog.");

    clear_restarts_a: assert property (  // (R1)
        r.state == HBWD_ARMED && cmd_valid && cmd_param == CMD_CLEAR
        |=> wdg_enabled && r.ms_count == '0)
        else $error("Clear did not restart the interval.");

    expiry_shutdown_a: assert property (  // (R3)
        s_expire |=> backplane_shutdown && !system_reset
            && r.state == HBWD_SHUTDOWN)
        else $error("Expiry did not raise shutdown.");

    shutdown_then_reset_a: assert property (  // (R4)
        s_shut_end |=> system_reset && backplane_shutdown)
        else $error("Reset did not follow the shutdown interval.");

    shutdown_first_a: assert property (  // (R5)
        $rose(system_reset) |-> $past(backplane_shutdown))
        else $error("Reset rose without prior shutdown.");

    reset_length_a: assert property (  // (R4)
        $rose(system_reset) |-> system_reset [*8] ##1 !system_reset)
        else $error("System reset pulse has the wrong length.");

    back_disabled_a: assert property (  // (R7)
        $fell(system_reset) |-> r.state == HBWD_DISABLED
            && !backplane_shutdown && cmd_ready)
        else $error("Watchdog not disabled after its reset.");

    no_cmd_in_seq_a: assert property (  // (R3)
        backplane_shutdown |-> !cmd_ready)
        else $error("Command taken during shutdown sequence.");

    // Outside the expiry sequence neither backplane line may be driven.
    idle_quiet_a: assert property (  // (R7)
        r.state inside {HBWD_DISABLED, HBWD_ARMED}
        |-> !backplane_shutdown && !system_reset)
        else $error("Sequence output seen outside the sequence.");

    // The boards need a head start, so shutdown never rises with reset.
    shutdown_alone_a: assert property (  // (R4)
        $rose(backplane_shutdown) |-> !system_reset)
        else $error("Shutdown rose together with the reset.");

    // The reset always rides on a standing shutdown line.
    reset_in_shut_a: assert property (  // (R5)
        system_reset |-> backplane_shutdown)
        else $error("Reset seen without the shutdown line.");

    // A late clear is refused and must not move the sequence out of shutdown.
    refused_ignored_a: assert property (  // (R3)
        cmd_valid && !cmd_ready && r.state == HBWD_SHUTDOWN && !tk.tick
        |=> r.state == HBWD_SHUTDOWN)
        else $error("Refused command changed the sequence.");

endmodule : hbwd_watchdog

`default_nettype wire

// file: verif/hbwd_host_model.sv
/*
 * Host-side partner of the heartbeat watchdog: sends one-shot commands
 * for the bench and, while told to, periodic clears.
 * Assumes the bench drives its controls on ref_clk.
 */
`timescale 1ns/100ps
`default_nettype none

module hbwd_host_model
    import hbwd_pkg::*;
(
    input  wire logic        ref_clk,    // 200 MHz clock.
    input  wire logic        arst_n,     // Async reset, active low.
    input  wire logic        send,       // One-shot command request.
    input  wire logic [1:0]  send_param, // Parameter of that command.
    input  wire logic        beat_on,    // Keep clearing periodically.
    input  wire logic [31:0] beat_gap,   // Cycles between clears.
    output logic             cmd_valid,  // Command strobe.
    output logic [1:0]       cmd_param,  // Command parameter.
    input  wire logic        cmd_ready   // Watchdog takes commands.
);
    int gap_cnt;

    wire logic beat_due = beat_on && (gap_cnt >= int'(beat_gap));

    // A request stands until taken; idle parameter toggles so a stale
    // value is never mistaken for a held one.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cmd_valid <= 1'b0;
            cmd_param <= 2'h3;
            gap_cnt   <= 0;
        end else begin
            gap_cnt <= gap_cnt + 1;
            if (!cmd_valid || cmd_ready) begin
                cmd_valid <= 1'b0;
                cmd_param <= ~cmd_param;
                if (send) begin
                    cmd_valid <= 1'b1;
                    cmd_param <= send_param;
                end else if (beat_due) begin
                    cmd_valid <= 1'b1;
                    cmd_param <= CMD_CLEAR;
                    gap_cnt   <= 0;
                end
            end
        end
    end
endmodule : hbwd_host_model

`default_nettype wire

// file: verif/hbwd_watchdog_tb.sv
/*
 * Self-checking bench of the heartbeat watchdog with a host model.
 * Assumes short tick and shutdown parameters to keep the run brief.
 */
`timescale 1ns/100ps
`default_nettype none

`define CHK(g, e, m) \
    begin n_compared++; if ((g) !== (e)) begin error_cnt++; \
    $display("Error %0t: %s", $time, m); end end

module hbwd_watchdog_tb;
    import hbwd_pkg::*;

    localparam int unsigned TK = 10;
    localparam logic [MS_W-1:0] SM = 12'h003;
    typedef struct packed { logic [1:0] p; logic en; } hbwd_row_t;

    logic ref_clk, arst_n, send, beat_on;
    logic [1:0] send_param, cmd_param;
    logic [31:0] beat_gap;
    logic cmd_valid, cmd_ready, wdg_enabled, backplane_shutdown;
    logic system_reset;
    logic bp_q = 1'b0, sr_q = 1'b0, ord_bad = 1'b0;
    int error_cnt = 0, n_compared = 0, cyc = 0, last_clr = 0;
    int bp_at = 0, sr_at = 0, sr_len = 0, i;
    int exp_to = int'(TIMEOUT_MS) * TK;
    int exp_sd = int'(SM) * TK;
    hbwd_row_t rows [9] = '{'{CMD_CLEAR, 1'b0}, '{CMD_DISABLE, 1'b0},
        '{2'h3, 1'b0}, '{CMD_ENABLE, 1'b1}, '{CMD_ENABLE, 1'b1},
        '{2'h3, 1'b1}, '{CMD_CLEAR, 1'b1}, '{CMD_DISABLE, 1'b0},
        '{CMD_ENABLE, 1'b1}};

    hbwd_watchdog #(.TICKS(TK), .SHUT_MS(SM)) dut_u (
        .ref_clk(ref_clk), .arst_n(arst_n), .cmd_valid(cmd_valid),
        .cmd_param(cmd_param), .cmd_ready(cmd_ready),
        .wdg_enabled(wdg_enabled),
        .backplane_shutdown(backplane_shutdown),
        .system_reset(system_reset));

    hbwd_host_model host_u (
        .ref_clk(ref_clk), .arst_n(arst_n), .send(send),
        .send_param(send_param), .beat_on(beat_on), .beat_gap(beat_gap),
        .cmd_valid(cmd_valid), .cmd_param(cmd_param),
        .cmd_ready(cmd_ready));

    // Free-running clock, 5 ns period.
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // Timestamps of clears, shutdown and reset edges, seen one edge late.
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        bp_q <= backplane_shutdown;
        sr_q <= system_reset;
        if (cmd_valid && cmd_ready && cmd_param == CMD_CLEAR)
            last_clr <= cyc;
        if (backplane_shutdown && !bp_q)
            bp_at <= cyc;
        if (system_reset && !sr_q)
            sr_at <= cyc;
        if (system_reset)
            sr_len <= sr_len + 1;
        if (system_reset && !backplane_shutdown)
            ord_bad <= 1'b1;
    end

    task automatic finish_test();
        if (error_cnt == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : finish_test

    // One command through the host model; effect settles after.
    task automatic cmd(input logic [1:0] p);
        @(posedge ref_clk);
        send <= 1'b1;
        send_param <= p;
        @(posedge ref_clk);
        send <= 1'b0;
        @(posedge ref_clk);
        #1;
    endtask : cmd

    function automatic logic hit(input int sel);
        case (sel)
            0: return backplane_shutdown === 1'b1;
            1: return system_reset === 1'b1;
            default: return system_reset === 1'b0;
        endcase
    endfunction : hit

    // Bounded wait; running out ends the run as a mismatch.
    task automatic wait_for(input int sel, input int bound);
        int k;
        k = 0;
        while (!hit(sel) && k < bound) begin
            @(posedge ref_clk);
            k++;
        end
        if (!hit(sel)) begin
            error_cnt++;
            $display("Error %0t: wait ran out", $time);
            finish_test();
        end
    endtask : wait_for

    // Main sequence: reset, command table, then expiry path.
    initial begin
        arst_n = 1'b0;
        send = 1'b0;
        send_param = 2'h0;
        beat_on = 1'b0;
        beat_gap = 32'h00004e20;
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'b1;
        #1;
        `CHK({cmd_ready, wdg_enabled}, 2'b10, "reset state")
        `CHK({backplane_shutdown, system_reset}, 2'b00, "reset out")
        for (i = 0; i < 9; i++) begin
            cmd(rows[i].p);
            `CHK(wdg_enabled, rows[i].en, "enable state")
        end
        @(posedge ref_clk);
        beat_on <= 1'b1;
        repeat (45000) @(posedge ref_clk);
        `CHK(bp_at == 0, 1'b1, "shutdown despite clears")
        `CHK(wdg_enabled, 1'b1, "not armed")
        beat_on <= 1'b0;
        wait_for(0, exp_to + 25000);
        #1;
        `CHK((bp_at-last_clr) inside {[exp_to:exp_to+4]}, 1'b1, "late")
        `CHK({cmd_ready, wdg_enabled}, 2'b00, "busy state")
        cmd(CMD_CLEAR);
        wait_for(1, exp_sd + 10);
        wait_for(2, 20);
        #1;
        `CHK((sr_at-bp_at) inside {[exp_sd-1:exp_sd+1]}, 1'b1, "delay")
        `CHK(sr_len == int'(RST_CYCLES), 1'b1, "reset length")
        `CHK(ord_bad, 1'b0, "reset without shutdown")
        `CHK(backplane_shutdown, 1'b0, "shutdown held")
        repeat (10) @(posedge ref_clk);
        #1;
        `CHK({cmd_ready, wdg_enabled}, 2'b10, "not disabled")
        // A reset in mid-run must drop an armed watchdog to disabled.
        cmd(CMD_ENABLE);
        `CHK(wdg_enabled, 1'b1, "re-enable")
        @(posedge ref_clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        arst_n <= 1'b1;
        #1;
        `CHK({cmd_ready, wdg_enabled}, 2'b10, "mid-run reset")
        finish_test();
    end
endmodule : hbwd_watchdog_tb

`default_nettype wire
